// File: rtl/sarcc_ctrl.sv
`timescale 1ns/1ps
module sarcc_ctrl
   import sarcc_pkg::*;
#(
   parameter int CONV_CYCLES = SARCC_CONV_CYCLES,
   parameter bit BIPOLAR = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_rc_n,
   input wire logic i_byte_sel,
   input wire logic i_cmp_above,
   output logic o_busy_n,
   output logic o_sample_hold,
   output logic [15:0] o_data,
   output logic o_data_oe
);
   localparam int BIT_CYCLES = CONV_CYCLES / SARCC_RES_BITS;
   localparam int CW = $clog2(CONV_CYCLES + 1);
   // Each bit decision lands two cycles before the end of its slot, so the
   // last decision has settled before the result latch is written.
   localparam int TICK_AT = BIT_CYCLES - 2;

   logic [1:0] cs_sync;
   logic [1:0] rc_sync;
   logic [1:0] byte_sync;
   logic [1:0] cmp_sync;
   sarcc_state_e state;
   logic [7:0] arm_cnt;
   logic [CW-1:0] conv_cnt;
   logic [4:0] bit_idx;
   logic [15:0] sar;
   logic [15:0] result;
   logic start_req;
   logic bit_tick;
   logic conv_end;
   logic [CW-1:0] busy_len;

   // True in the last cycle of a running conversion, where the result is
   // latched; the sequencer and the output latch both decode it.
   function automatic logic conv_last(input sarcc_state_e st, input logic [CW-1:0] cnt);
      conv_last = (st == SARCC_CONV) && (cnt == CW'(CONV_CYCLES - 1));
   endfunction : conv_last

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         // Selects preset to their idle high level, so that no false start
         // request is seen just after reset.
         cs_sync <= 2'h3;
         rc_sync <= 2'h3;
         byte_sync <= 2'h0;
         cmp_sync <= 2'h0;
      end else begin
         cs_sync <= {cs_sync[0], i_cs_n};
         rc_sync <= {rc_sync[0], i_rc_n};
         byte_sync <= {byte_sync[0], i_byte_sel};
         cmp_sync <= {cmp_sync[0], i_cmp_above};
      end
   end

   // Both selects low after synchronising; covers either operating mode.
   assign start_req = !cs_sync[1] && !rc_sync[1];
   assign bit_tick = (conv_cnt % CW'(BIT_CYCLES)) == CW'(TICK_AT);
   assign conv_end = conv_last(state, conv_cnt);

   // ----------------------------------------
   // Busy length monitor for the checks
   // ----------------------------------------
   // Counts clock edges at which busy was seen low; cleared while busy is
   // high, so at the rising edge of busy it holds the full low time.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         busy_len <= '0;
      end else if (o_busy_n) begin
         busy_len <= '0;
      end else begin
         busy_len <= busy_len + CW'(1);
      end
   end

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= SARCC_IDLE;
         arm_cnt <= 8'h00;
         conv_cnt <= '0;
      end else begin
         unique case (state)
            SARCC_IDLE: begin
               arm_cnt <= 8'h00;
               conv_cnt <= '0;
               if (start_req) begin
                  state <= SARCC_ARM;
               end
            end
            SARCC_ARM: begin
               if (!start_req) begin
                  state <= SARCC_IDLE;
               end else if (arm_cnt == 8'(SARCC_START_CYCLES - 2)) begin
                  state <= SARCC_CONV;
               end else begin
                  arm_cnt <= arm_cnt + 8'h01;
               end
            end
            SARCC_CONV: begin
               // fixed conversion time
               // The last count of conv_cnt ends the conversion; the selects are not looked
               // at until the sequencer is back in idle.
               if (conv_end) begin
                  state <= SARCC_IDLE;
               end else begin
                  conv_cnt <= conv_cnt + 1'b1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Successive approximation register
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sar <= 16'h0000;
         bit_idx <= 5'h0f;
      // Outside a conversion the register sits at its first trial value, so
      // the top bit is under test from the first cycle of the next conversion.
      end else if (state != SARCC_CONV) begin
         sar <= 16'h8000;
         bit_idx <= 5'h0f;
      end else if (bit_tick && bit_idx != 5'h1f) begin
         sar[bit_idx[3:0]] <= cmp_sync[1];
         if (bit_idx != 5'h00) begin
            sar[bit_idx[3:0] - 4'h1] <= 1'b1;
         end
         bit_idx <= bit_idx - 5'h01;
      end
   end

   // ----------------------------------------
   // Output latch, busy and sample/hold
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         result <= SARCC_RESULT_RST;
         o_busy_n <= 1'b1;
         o_sample_hold <= 1'b0;
      end else begin
         if (conv_end) begin
            result <= BIPOLAR ? {~sar[15], sar[14:0]} : sar;
         end
         // busy falls at start
         // Busy follows the state one cycle late, so it rises one cycle after
         // the result latch has been written.
         o_busy_n <= !(state == SARCC_CONV);
         o_sample_hold <= (state == SARCC_CONV);
      end
   end

   // ----------------------------------------
   // Data port
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_data <= 16'h0000;
         o_data_oe <= 1'b0;
      end else begin
         o_data_oe <= rc_sync[1] && !cs_sync[1] && state == SARCC_IDLE && o_busy_n;
         o_data <= byte_sync[1] ? {result[7:0], result[7:0]} : result;
      end
   end

   // ----------------------------------------
   // Checks: start and restart
   // ----------------------------------------
   // A start must be qualified for the full low time, and a running
   // conversion must ignore the selects until it has finished.
   a_start_qual: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == SARCC_IDLE && start_req) |=> state == SARCC_ARM)
      else $error("start not taken");
   a_arm_abort: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == SARCC_ARM && !start_req) |=> state == SARCC_IDLE)
      else $error("short start pulse not dropped");
   a_arm_qual: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state == SARCC_ARM |-> $past(start_req))
      else $error("arming without a start request");
   a_conv_entry: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(state == SARCC_CONV) |-> $past(start_req) && $past(state) == SARCC_ARM)
      else $error("conversion entered without a qualified start");
   a_no_restart: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == SARCC_CONV && !conv_end) |=> state == SARCC_CONV)
      else $error("conversion restarted");
   a_cnt_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state != SARCC_CONV |=> conv_cnt == '0)
      else $error("conversion counter not cleared");

   // ----------------------------------------
   // Checks: busy, sampler and result
   // ----------------------------------------
   // Busy must cover the whole conversion, and the latch must already hold
   // the finished code when busy rises.
   a_busy_low_len: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $fell(o_busy_n) |-> !o_busy_n [*8])
      else $error("busy pulse too short");
   a_busy_len: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_busy_n) |-> busy_len == CW'(CONV_CYCLES))
      else $error("busy low time differs from the conversion time");
   a_busy_follow: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == SARCC_CONV && conv_cnt == '0) |=> !o_busy_n)
      else $error("busy not low at start");
   a_busy_start: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(state == SARCC_CONV) |=> $fell(o_busy_n))
      else $error("busy did not fall at start");
   a_busy_end: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_busy_n) |-> $past(conv_end, 2))
      else $error("busy rose before the result was latched");
   a_result_first: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_busy_n) |-> result == ($past(sar, 2) ^ {BIPOLAR, 15'h0000}))
      else $error("result code wrong at busy rise");
   a_result_steady: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !conv_end |=> $stable(result))
      else $error("result changed outside the latch cycle");
   a_hold_conv: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state == SARCC_CONV |=> o_sample_hold)
      else $error("sampler not in hold during conversion");
   a_sh_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_busy_n) |-> !o_sample_hold)
      else $error("sampler still in hold after conversion");
   a_bit_order: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == SARCC_CONV && bit_tick && bit_idx != 5'h1f) |=> bit_idx == $past(bit_idx) - 5'h01)
      else $error("bit decisions out of order");
   a_sar_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state != SARCC_CONV |=> sar == 16'h8000)
      else $error("approximation register not reset to first trial");

   // ----------------------------------------
   // Checks: data port
   // ----------------------------------------
   a_float_rc_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !rc_sync[1] |=> !o_data_oe)
      else $error("data driven while read/convert low");
   a_busy_hides: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !o_busy_n |-> !o_data_oe)
      else $error("data driven during conversion");
   a_oe_cs: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_data_oe |-> $past(!cs_sync[1]))
      else $error("data driven without chip select");
   a_byte_swap: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      byte_sync[1] |=> o_data[15:8] == $past(result[7:0]))
      else $error("low byte not on upper pins");
   a_word_order: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !byte_sync[1] |=> o_data == $past(result))
      else $error("word order wrong");

   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   c_conv_done: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_busy_n));
   c_read_word: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_data_oe && !byte_sync[1]);
   c_read_byte: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_data_oe && byte_sync[1]);
   c_start_ignored: cover property (@(posedge i_ref_clk) disable iff (i_rst) state == SARCC_CONV && start_req);
   c_arm_abort: cover property (@(posedge i_ref_clk) disable iff (i_rst) state == SARCC_ARM && !start_req);
endmodule : sarcc_ctrl

// File: rtl/sarcc_pkg.sv
package sarcc_pkg;
   // Conversion pacing: about 7 us from busy falling to busy rising.
   localparam int SARCC_CLK_MHZ = 200;
   localparam int SARCC_CONV_TIME_NS = 7000;
   localparam int SARCC_CONV_CYCLES = (SARCC_CONV_TIME_NS * SARCC_CLK_MHZ) / 1000;
   // Least low time of the start request, rounded up to whole cycles.
   localparam int SARCC_START_MIN_NS = 40;
   localparam int SARCC_START_CYCLES = (SARCC_START_MIN_NS * SARCC_CLK_MHZ + 999) / 1000;
   localparam int SARCC_RES_BITS = 16;
   localparam logic [15:0] SARCC_RESULT_RST = 16'h0000;
   typedef enum logic [1:0] {SARCC_IDLE, SARCC_ARM, SARCC_CONV} sarcc_state_e;
endpackage : sarcc_pkg

// File: verification/sarcc_host.sv
`timescale 1ns/1ps
module sarcc_host (
   input wire logic i_clk,
   input wire logic i_data_oe,
   input wire logic [15:0] i_data,
   output logic o_cs_n,
   output logic o_rc_n,
   output logic o_byte_sel
);
   logic [15:0] last = 16'h0000;
   logic [15:0] bus;
   // A floating port reads as the inverse of the last word driven.
   assign bus = i_data_oe ? i_data : ~last;
   always_ff @(posedge i_clk) begin
      if (i_data_oe) begin
         last <= i_data;
      end
   end
   initial begin
      o_cs_n = 1'b1;
      o_rc_n = 1'b1;
      o_byte_sel = 1'b0;
   end
   task automatic conv(input bit m2, input int w);
      @(posedge i_clk);
      o_cs_n <= m2;
      o_rc_n <= !m2;
      repeat (2) @(posedge i_clk);
      o_cs_n <= 1'b0;
      o_rc_n <= 1'b0;
      repeat (w) @(posedge i_clk);
      o_rc_n <= 1'b1;
      o_cs_n <= m2;
   endtask : conv
   task automatic rd(input bit b, output logic [15:0] d);
      @(posedge i_clk);
      o_byte_sel <= b;
      o_rc_n <= 1'b1;
      o_cs_n <= 1'b0;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
      d = bus;
      @(posedge i_clk);
      o_cs_n <= 1'b1;
   endtask : rd
endmodule : sarcc_host

// File: verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   localparam int CONV = 64;
   logic clk, rst, cs_n, rc_n, bsel, cmp;
   logic busy_n, busy_b, sh, sh_b, oe, oe_b;
   logic [15:0] dat, dat_b;
   int n_fail = 0;
   int samples_checked = 0;
   int run = 0;
   int len = 0;
   sarcc_ctrl #(.CONV_CYCLES(CONV), .BIPOLAR(1'b0)) dut (.i_ref_clk(clk), .i_rst(rst), .i_cs_n(cs_n),
      .i_rc_n(rc_n), .i_byte_sel(bsel), .i_cmp_above(cmp), .o_busy_n(busy_n), .o_sample_hold(sh),
      .o_data(dat), .o_data_oe(oe));
   sarcc_ctrl #(.CONV_CYCLES(CONV), .BIPOLAR(1'b1)) dut_b (.i_ref_clk(clk), .i_rst(rst), .i_cs_n(cs_n),
      .i_rc_n(rc_n), .i_byte_sel(bsel), .i_cmp_above(cmp), .o_busy_n(busy_b), .o_sample_hold(sh_b),
      .o_data(dat_b), .o_data_oe(oe_b));
   sarcc_host host (.i_clk(clk), .i_data_oe(oe), .i_data(dat), .o_cs_n(cs_n), .o_rc_n(rc_n),
      .o_byte_sel(bsel));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (busy_n === 1'b0) begin
         run <= run + 1;
      end else if (run != 0) begin
         len <= run;
         run <= 0;
      end
   end
   task automatic conclude;
      $display("checked=%0d failed=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic t_glitch;
      host.conv(1'b0, 1);
      repeat (30) @(posedge clk);
      `CHK(busy_n, 1'b1)
      repeat (400) @(posedge clk);
      $display("t_glitch done");
   endtask : t_glitch
   task automatic t_conv(input bit m2, input bit c, input bit again, input logic [15:0] eu,
      input logic [15:0] eb);
      logic [15:0] d;
      int k;
      @(posedge clk);
      cmp <= c;
      host.conv(m2, 10);
      k = 0;
      while (busy_n === 1'b1 && k < 40) begin
         @(posedge clk);
         k++;
      end
      repeat (5) @(posedge clk);
      `CHK(busy_n, 1'b0)
      `CHK(oe, 1'b0)
      `CHK(sh, 1'b1)
      if (again) host.conv(m2, 10);
      k = 0;
      while (busy_n !== 1'b1 && k < 300) begin
         @(posedge clk);
         k++;
      end
      repeat (2) @(posedge clk);
      `CHK(len, CONV)
      repeat (20) @(posedge clk);
      `CHK(busy_n, 1'b1)
      `CHK(sh, 1'b0)
      host.rd(1'b0, d);
      `CHK(d, eu)
      `CHK(dat_b, eb)
      `CHK(oe_b, 1'b1)
      host.rd(1'b1, d);
      `CHK(d, {2{eu[7:0]}})
      `CHK(dat_b, {2{eb[7:0]}})
      repeat (400) @(posedge clk);
      $display("t_conv mode2=%0d cmp=%0d done", m2, c);
   endtask : t_conv
   initial begin
      rst = 1'b1;
      cmp = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_glitch();
      t_conv(1'b0, 1'b1, 1'b1, 16'hffff, 16'h7fff);
      t_conv(1'b1, 1'b0, 1'b0, 16'h0000, 16'h8000);
      t_conv(1'b1, 1'b1, 1'b1, 16'hffff, 16'h7fff);
      conclude();
   end
   initial begin
      repeat (8000) @(posedge clk);
      n_fail++;
      conclude();
   end
endmodule : tb_top
